// *** pmic_config_registers.sv ***
// Two configuration registers with the pin, supervisor and power-good logic they steer.
// Assumes the serial engine presents subaddress accesses synchronous to mclk_i.
// Functional notes
// RULE1: Push-button reset needs an 8 s hold when the hold bit is 0 and 15 s when it is 1.
// RULE2: The second general output is open-drain when its buffer bit is 0, push-pull when 1.
// RULE3: With the role bit at 0 pin one is an open-drain output and output two is independent.
// RULE4: With the role bit at 1 pin one is an input whose level drives output two.
// RULE5: Power-good rises 10, 20, 50 or 150 ms after the rails are good and falls at once.
// RULE6: Strictness 1 gives tight falling limits with overvoltage watch, 0 wide limits without.
// RULE7: With the converter-reset bit at 0 pin three is a general open-drain output.
// RULE8: With the converter-reset bit at 1 pin three is a warm-reset input for converters 1, 2.
// RULE9: Switch three limit codes 0 to 3 select 100, 200, 500, 1000 mA, reset code 0.
// RULE10: Switch two limit codes 0 to 3 select 100, 200, 500, 1000 mA, reset code 0.
// RULE11: The first register sits at 0x13 and resets to 0x4C.
// RULE12: The second register sits at 0x14, resets to 0xC0 and has reserved bits 5 to 4.
// RULE13: While the converter-reset bit is 1 the pin three level bit is ignored.
// RULE14: Reserved bits of the second register read zero and ignore writes.
module pmic_config_registers
#(
    parameter int HOLD_SHORT = pmic_cfg_pkg::HOLD_SHORT_CYC,
    parameter int HOLD_LONG  = pmic_cfg_pkg::HOLD_LONG_CYC,
    parameter int PG_DLY0    = pmic_cfg_pkg::PG_DLY0_CYC,
    parameter int PG_DLY1    = pmic_cfg_pkg::PG_DLY1_CYC,
    parameter int PG_DLY2    = pmic_cfg_pkg::PG_DLY2_CYC,
    parameter int PG_DLY3    = pmic_cfg_pkg::PG_DLY3_CYC
)
(
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       button_held_i,
    output logic            button_reset_o,
    input  wire logic       rails_ok_i,
    output logic            power_good_o,
    input  wire logic       out_one_level_i,
    input  wire logic       out_two_level_i,
    input  wire logic       out_three_level_i,
    input  wire logic       io_pin_one_i,
    output logic            io_pin_one_o,
    output logic            io_pin_one_oe_o,
    output logic            general_out_two_o,
    output logic            general_out_two_oe_o,
    input  wire logic       io_pin_three_i,
    output logic            io_pin_three_o,
    output logic            io_pin_three_oe_o,
    output logic            converter_warm_reset_o,
    output logic            tight_limits_o,
    output logic            overvoltage_watch_o,
    output logic      [1:0] undervoltage_lockout_threshold_o,
    output logic            lockout_hysteresis_sel_o,
    output logic      [1:0] switch_three_limit_sel_o,
    output logic      [1:0] switch_two_limit_sel_o
);
    import pmic_cfg_pkg::*;
    logic [7:0]  cfg_one_q, cfg_one_d, cfg_two_q, cfg_two_d, rdata_d;
    logic [31:0] hold_cnt_q, hold_cnt_d, pg_cnt_q, pg_cnt_d, hold_lim, pg_lim;
    logic        fired_q, fired_d, btn_rst_d, pg_d;
    pg_state_t   pg_q, pg_d_st;
    logic        p1_o_d, p1_oe_d, g2_o_d, g2_oe_d, g2_lvl, p3_o_d, p3_oe_d, wrst_d;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    // Write decode and read mux
    always_comb
    begin
        cfg_one_d = cfg_one_q;
        cfg_two_d = cfg_two_q;
        rdata_d   = reg_rdata_o;
        // RULE11: first register decode
        if (reg_wr_i && reg_addr_i == SYS_CFG_ONE_ADDR)
            cfg_one_d = reg_wdata_i;
        // RULE14: reserved bits masked
        if (reg_wr_i && reg_addr_i == SYS_CFG_TWO_ADDR)
            cfg_two_d = reg_wdata_i & SYS_CFG_TWO_MASK;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                SYS_CFG_ONE_ADDR: rdata_d = cfg_one_q;
                SYS_CFG_TWO_ADDR: rdata_d = cfg_two_q & SYS_CFG_TWO_MASK;
                default:          rdata_d = 8'h00;   // Unmapped reads as zero
            endcase
        end
    end
    // Register storage
    always_ff @(posedge mclk_i)
    begin
        // RULE12: reset values
        if (!nrst_i)
        begin
            cfg_one_q   <= SYS_CFG_ONE_RST;
            cfg_two_q   <= SYS_CFG_TWO_RST;
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            cfg_one_q   <= cfg_one_d;
            cfg_two_q   <= cfg_two_d;
            reg_rdata_o <= rdata_d;
        end
    end

    // ----------------------------------------
    // Push-button hold timer
    // ----------------------------------------
    // Count while held, one pulse per press
    always_comb
    begin
        // RULE1: hold time select
        hold_lim   = cfg_one_q[HOLD_TIME_BIT] ? 32'(HOLD_LONG) : 32'(HOLD_SHORT);
        hold_cnt_d = 32'h0000_0000;
        fired_d    = 1'b0;
        btn_rst_d  = 1'b0;
        if (button_held_i)
        begin
            fired_d    = fired_q;
            hold_cnt_d = hold_cnt_q;
            if (!fired_q)
            begin
                if (hold_cnt_q >= hold_lim - 32'h0000_0001)
                begin
                    btn_rst_d = 1'b1;
                    fired_d   = 1'b1;
                end
                else
                    hold_cnt_d = hold_cnt_q + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // Power-good delay
    // ----------------------------------------
    // Delay on rise only
    always_comb
    begin
        unique case (cfg_one_q[PG_DELAY_MSB:PG_DELAY_LSB])
            2'h0: pg_lim = 32'(PG_DLY0);
            2'h1: pg_lim = 32'(PG_DLY1);
            2'h2: pg_lim = 32'(PG_DLY2);
            2'h3: pg_lim = 32'(PG_DLY3);
        endcase
        pg_d_st  = pg_q;
        pg_cnt_d = 32'h0000_0000;
        pg_d     = 1'b0;
        // RULE5: falling edge is immediate
        if (!rails_ok_i)
            pg_d_st = PG_LOW;
        else
        begin
            unique case (pg_q)
                PG_LOW:  pg_d_st = PG_WAIT;
                PG_WAIT:
                begin
                    if (pg_cnt_q >= pg_lim - 32'h0000_0001)
                    begin
                        pg_d_st = PG_HIGH;
                        pg_d    = 1'b1;
                    end
                    else
                        pg_cnt_d = pg_cnt_q + 32'h0000_0001;
                end
                PG_HIGH: pg_d = 1'b1;
                default: pg_d_st = PG_LOW;
            endcase
        end
    end

    // ----------------------------------------
    // Pin control
    // ----------------------------------------
    // Pin roles and buffer types
    always_comb
    begin
        // RULE3: pin one as open-drain output
        p1_o_d  = 1'b0;
        p1_oe_d = !out_one_level_i;
        g2_lvl  = out_two_level_i;
        // RULE4: pin one drives output two
        if (cfg_one_q[PIN_ROLE_BIT])
        begin
            p1_oe_d = 1'b0;
            g2_lvl  = io_pin_one_i;
        end
        // RULE2: open-drain or push-pull
        g2_o_d  = cfg_one_q[BUF_TYPE_BIT] ? g2_lvl : 1'b0;
        g2_oe_d = cfg_one_q[BUF_TYPE_BIT] ? 1'b1 : !g2_lvl;
        // RULE7: pin three general output
        p3_o_d  = 1'b0;
        p3_oe_d = !out_three_level_i;
        wrst_d  = 1'b0;
        // RULE8: warm-reset input, RULE13: level ignored
        if (cfg_two_q[CONV_RST_BIT])
        begin
            p3_oe_d = 1'b0;
            wrst_d  = !io_pin_three_i;
        end
    end
    // Timers, sequencing and pin registers
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            hold_cnt_q             <= 32'h0000_0000;
            fired_q                <= 1'b0;
            button_reset_o         <= 1'b0;
            pg_q                   <= PG_LOW;
            pg_cnt_q               <= 32'h0000_0000;
            power_good_o           <= 1'b0;
            io_pin_one_o           <= 1'b0;
            io_pin_one_oe_o        <= 1'b0;
            general_out_two_o      <= 1'b0;
            general_out_two_oe_o   <= 1'b0;
            io_pin_three_o         <= 1'b0;
            io_pin_three_oe_o      <= 1'b0;
            converter_warm_reset_o <= 1'b0;
        end
        else
        begin
            hold_cnt_q             <= hold_cnt_d;
            fired_q                <= fired_d;
            button_reset_o         <= btn_rst_d;
            pg_q                   <= pg_d_st;
            pg_cnt_q               <= pg_cnt_d;
            power_good_o           <= pg_d;
            io_pin_one_o           <= p1_o_d;
            io_pin_one_oe_o        <= p1_oe_d;
            general_out_two_o      <= g2_o_d;
            general_out_two_oe_o   <= g2_oe_d;
            io_pin_three_o         <= p3_o_d;
            io_pin_three_oe_o      <= p3_oe_d;
            converter_warm_reset_o <= wrst_d;
        end
    end

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    // RULE6: strictness drives limits and overvoltage watch
    assign tight_limits_o                   = cfg_one_q[SUPERVISOR_STRICTNESS_BIT];
    assign overvoltage_watch_o              = cfg_one_q[SUPERVISOR_STRICTNESS_BIT];
    assign undervoltage_lockout_threshold_o = cfg_one_q[UNDERVOLTAGE_LOCKOUT_THRESHOLD_MSB:UNDERVOLTAGE_LOCKOUT_THRESHOLD_LSB];
    assign lockout_hysteresis_sel_o         = cfg_two_q[HYST_BIT];
    // RULE9: switch three limit code
    assign switch_three_limit_sel_o         = cfg_two_q[SW3_LIM_MSB:SW3_LIM_LSB];
    // RULE10: switch two limit code
    assign switch_two_limit_sel_o           = cfg_two_q[SW2_LIM_MSB:SW2_LIM_LSB];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_reset_vals;
        @(posedge mclk_i) $rose(nrst_i) |-> cfg_one_q == SYS_CFG_ONE_RST
            && cfg_two_q == SYS_CFG_TWO_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // RULE11
    property p_pg_fall;
        @(posedge mclk_i) disable iff (!nrst_i) !rails_ok_i |=> !power_good_o;
    endproperty
    a_pg_fall: assert property (p_pg_fall) else $error("power good late fall"); // RULE5
    property p_pg_rise;
        @(posedge mclk_i) disable iff (!nrst_i)
            $rose(power_good_o) |-> $past(pg_cnt_q) == $past(pg_lim) - 32'h0000_0001;
    endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("power good early"); // RULE5
    property p_od_two;
        @(posedge mclk_i) disable iff (!nrst_i)
            !cfg_one_q[BUF_TYPE_BIT] ##1 general_out_two_oe_o |-> !general_out_two_o;
    endproperty
    a_od_two: assert property (p_od_two) else $error("open-drain drove high"); // RULE2
    property p_pp_two;
        @(posedge mclk_i) disable iff (!nrst_i) cfg_one_q[BUF_TYPE_BIT] |=> general_out_two_oe_o;
    endproperty
    a_pp_two: assert property (p_pp_two) else $error("push-pull not driven"); // RULE2
    property p_pin_one_in;
        @(posedge mclk_i) disable iff (!nrst_i)
            cfg_one_q[PIN_ROLE_BIT] && cfg_one_q[BUF_TYPE_BIT] |=>
                !io_pin_one_oe_o && general_out_two_o == $past(io_pin_one_i);
    endproperty
    a_pin_one_in: assert property (p_pin_one_in) else $error("pin one not steering"); // RULE4
    property p_pin_three;
        @(posedge mclk_i) disable iff (!nrst_i) cfg_two_q[CONV_RST_BIT] |=>
            !io_pin_three_oe_o && converter_warm_reset_o == !$past(io_pin_three_i);
    endproperty
    a_pin_three: assert property (p_pin_three) else $error("pin three misused"); // RULE13
    property p_rsvd_read;
        @(posedge mclk_i) disable iff (!nrst_i)
            reg_rd_i && reg_addr_i == SYS_CFG_TWO_ADDR |=> reg_rdata_o[5:4] == 2'h0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits set"); // RULE14
    property p_btn_pulse;
        @(posedge mclk_i) disable iff (!nrst_i) button_reset_o |=> !button_reset_o;
    endproperty
    a_btn_pulse: assert property (p_btn_pulse) else $error("reset pulse repeated"); // RULE1

endmodule

// *** pmic_cfg_pkg.sv ***
// Constants for the two power-management configuration registers.
// Assumes a 20 MHz system clock and an external serial engine feeding subaddress accesses.
package pmic_cfg_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] SYS_CFG_ONE_ADDR = 8'h13;
    localparam logic [7:0] SYS_CFG_TWO_ADDR = 8'h14;
    localparam logic [7:0] SYS_CFG_ONE_RST  = 8'h4C;
    localparam logic [7:0] SYS_CFG_TWO_RST  = 8'hC0;
    localparam logic [7:0] SYS_CFG_TWO_MASK = 8'hCF;   // Bits 5-4 reserved

    // ----------------------------------------
    // Field positions, first register
    // ----------------------------------------
    localparam int HOLD_TIME_BIT     = 7;
    localparam int BUF_TYPE_BIT      = 6;
    localparam int PIN_ROLE_BIT      = 5;
    localparam int PG_DELAY_MSB      = 4;
    localparam int PG_DELAY_LSB      = 3;
    localparam int SUPERVISOR_STRICTNESS_BIT        = 2;
    localparam int UNDERVOLTAGE_LOCKOUT_THRESHOLD_MSB          = 1;
    localparam int UNDERVOLTAGE_LOCKOUT_THRESHOLD_LSB          = 0;

    // ----------------------------------------
    // Field positions, second register
    // ----------------------------------------
    localparam int CONV_RST_BIT      = 7;
    localparam int HYST_BIT          = 6;
    localparam int SW3_LIM_MSB       = 3;
    localparam int SW3_LIM_LSB       = 2;
    localparam int SW2_LIM_MSB       = 1;
    localparam int SW2_LIM_LSB       = 0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint CLK_HZ         = 20_000_000;
    localparam longint HOLD_SHORT_S   = 8;
    localparam longint HOLD_LONG_S    = 15;
    localparam longint PG_DLY0_MS     = 10;
    localparam longint PG_DLY1_MS     = 20;
    localparam longint PG_DLY2_MS     = 50;
    localparam longint PG_DLY3_MS     = 150;
    localparam int HOLD_SHORT_CYC     = int'(HOLD_SHORT_S * CLK_HZ);
    localparam int HOLD_LONG_CYC      = int'(HOLD_LONG_S * CLK_HZ);
    localparam int PG_DLY0_CYC        = int'(PG_DLY0_MS * CLK_HZ / 1000);
    localparam int PG_DLY1_CYC        = int'(PG_DLY1_MS * CLK_HZ / 1000);
    localparam int PG_DLY2_CYC        = int'(PG_DLY2_MS * CLK_HZ / 1000);
    localparam int PG_DLY3_CYC        = int'(PG_DLY3_MS * CLK_HZ / 1000);

    // Power-good sequencing states
    typedef enum logic [1:0] {
        PG_LOW  = 2'b00,
        PG_WAIT = 2'b01,
        PG_HIGH = 2'b10
    } pg_state_t;

endpackage

// *** host_model.sv ***
// Host model for the configuration register port: subaddress writes and reads.
// Assumes mclk_i comes from the bench; all strobes change on falling edges.
module host_model
(
    input  wire logic       mclk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // One write; address and data inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge mclk_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask

    // One read; data taken the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge mclk_i);
        d          = reg_rdata_i;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
    endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the configuration register block.
// Assumes shortened hold and delay parameters; inputs move on falling edges.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i = 1'b0;
    logic nrst_i, button_held_i, rails_ok_i, io_pin_one_i, io_pin_three_i;
    logic out_one_level_i, out_two_level_i, out_three_level_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
    logic reg_wr_i, reg_rd_i, button_reset_o, power_good_o, io_pin_one_o, io_pin_one_oe_o;
    logic general_out_two_o, general_out_two_oe_o, io_pin_three_o, io_pin_three_oe_o;
    logic converter_warm_reset_o, tight_limits_o, overvoltage_watch_o, lockout_hysteresis_sel_o;
    logic [1:0] undervoltage_lockout_threshold_o, switch_three_limit_sel_o;
    logic [1:0] switch_two_limit_sel_o;
    int miscompares = 0;
    int n_tests = 0;
    int n;
    localparam int HOLD_S = 20;
    localparam int HOLD_L = 30;
    localparam int DLY0   = 5;
    localparam int DLY1   = 8;
    localparam int DLY2   = 12;
    localparam int DLY3   = 16;
    int dly[4] = '{DLY0, DLY1, DLY2, DLY3};
    int hold[2] = '{HOLD_S, HOLD_L};

    // Clock, 50 ns period
    always #25 mclk_i = ~mclk_i;

    pmic_config_registers #(.HOLD_SHORT(HOLD_S), .HOLD_LONG(HOLD_L), .PG_DLY0(DLY0),
        .PG_DLY1(DLY1), .PG_DLY2(DLY2), .PG_DLY3(DLY3)) DUT (.*);

    host_model host (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));

    // Verdict and end of run
    task automatic summarize();
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge mclk_i);
    endtask

    // Bounded wait for power-good or the button pulse
    task automatic wait_sig(input bit btn, output int cnt);
        cnt = 0;
        while ((btn ? button_reset_o : power_good_o) !== 1'b1)
        begin
            @(negedge mclk_i);
            cnt++;
            if (cnt > 100)
            begin
                miscompares++;
                summarize();
            end
        end
    endtask

    initial
    begin
        {nrst_i, button_held_i, rails_ok_i} = 3'b000;
        {io_pin_one_i, io_pin_three_i} = 2'b11;
        {out_one_level_i, out_two_level_i, out_three_level_i} = 3'b111;
        tick(16);
        nrst_i = 1'b1;
        // -------------------------------
        // Reset values and map
        // -------------------------------
        host.rd(8'h13, d); `CHK(d, 8'h4C)
        host.rd(8'h14, d); `CHK(d, 8'hC0)
        `CHK({tight_limits_o, overvoltage_watch_o}, 2'b11)
        `CHK({undervoltage_lockout_threshold_o, lockout_hysteresis_sel_o}, 3'b001)
        `CHK({switch_three_limit_sel_o, switch_two_limit_sel_o}, 4'h0)
        `CHK({power_good_o, button_reset_o}, 2'b00)
        host.wr(8'h15, 8'hFF);
        host.rd(8'h15, d); `CHK(d, 8'h00)
        host.rd(8'h13, d); `CHK(d, 8'h4C)
        host.wr(8'h14, 8'h30);
        host.rd(8'h14, d); `CHK(d, 8'h00)
        `CHK(lockout_hysteresis_sel_o, 1'b0)
        for (int c = 0; c < 4; c++)
        begin
            host.wr(8'h14, {4'hF, 2'(c), ~2'(c)});
            host.rd(8'h14, d); `CHK(d, {4'hC, 2'(c), ~2'(c)})
            `CHK(switch_three_limit_sel_o, 2'(c))
            `CHK(switch_two_limit_sel_o, ~2'(c))
        end
        host.wr(8'h13, 8'h48); tick(1);
        `CHK({tight_limits_o, overvoltage_watch_o}, 2'b00)
        host.wr(8'h13, 8'h4F); tick(1);
        `CHK({tight_limits_o, undervoltage_lockout_threshold_o}, 3'b111)
        // pin one independent, output two buffer type
        host.wr(8'h13, 8'h0C);
        {out_one_level_i, out_two_level_i} = 2'b00; tick(2);
        `CHK({io_pin_one_oe_o, io_pin_one_o}, 2'b10)
        `CHK({general_out_two_oe_o, general_out_two_o}, 2'b10)
        {out_one_level_i, out_two_level_i} = 2'b11; tick(2);
        `CHK(io_pin_one_oe_o, 1'b0)
        `CHK(general_out_two_oe_o, 1'b0)
        host.wr(8'h13, 8'h4C); tick(2);
        `CHK({general_out_two_oe_o, general_out_two_o}, 2'b11)
        out_two_level_i = 1'b0; tick(2);
        `CHK({general_out_two_oe_o, general_out_two_o}, 2'b10)
        host.wr(8'h13, 8'h6C);
        out_one_level_i = 1'b0; out_two_level_i = 1'b1; io_pin_one_i = 1'b0; tick(2);
        `CHK({io_pin_one_oe_o, general_out_two_o}, 2'b00)
        io_pin_one_i = 1'b1; tick(2);
        `CHK(general_out_two_o, 1'b1)
        out_three_level_i = 1'b0; io_pin_three_i = 1'b0; tick(2);
        `CHK({converter_warm_reset_o, io_pin_three_oe_o}, 2'b10)
        io_pin_three_i = 1'b1; tick(2);
        `CHK(converter_warm_reset_o, 1'b0)
        host.wr(8'h14, 8'h40); io_pin_three_i = 1'b0; tick(2);
        `CHK({converter_warm_reset_o, io_pin_three_oe_o, io_pin_three_o}, 3'b010)
        out_three_level_i = 1'b1; tick(2);
        `CHK(io_pin_three_oe_o, 1'b0)
        // power-good rise delay per code, prompt fall
        for (int c = 0; c < 4; c++)
        begin
            host.wr(8'h13, {3'b010, 2'(c), 3'b100});
            rails_ok_i = 1'b1;
            wait_sig(1'b0, n);
            `CHK(n >= dly[c] + 1 && n <= dly[c] + 2, 1'b1)
            rails_ok_i = 1'b0; tick(1);
            `CHK(power_good_o, 1'b0)
        end
        for (int t = 0; t < 2; t++)
        begin
            host.wr(8'h13, {1'(t), 7'h4C});
            button_held_i = 1'b1;
            wait_sig(1'b1, n);
            `CHK(n >= hold[t] && n <= hold[t] + 2, 1'b1)
            tick(1);
            `CHK(button_reset_o, 1'b0)
            button_held_i = 1'b0; tick(2);
        end
        summarize();
    end
endmodule
